// [ibm_map.vh]
// What this block does
// - at reset the access enable takes the inverted strap pin level
// - with checking on, frames whose destination differs from switch address are discarded
// - writing one to the reset bit restarts the state machine; bit clears itself
// - responses go to the queue chosen by a two-bit field, default queue one
// - three-bit field selects management port; codes three to seven select none
// - sixteen-bit tag field identifies management frames, default 40FE
// - good-frame flag sets when a valid management frame arrives
// - transmit-done flag sets once the response frame has been sent
// - execution-done flag sets after all commands of a frame have executed
// - done and error flags hold until the next frame with a matching tag
// - address-mismatch flag sets when destination differs from switch address
// - address-mismatch flag can only set while checking is enabled
// - format error flags when format field is not 9800
// - access code error flags when code is neither 0001 nor 0002
// - command error flags on an unrecognised command code
// - frames over 320 bytes raise the oversize flag
// - the 320 byte limit includes eight zero bytes and the check sequence
// - an oversized management frame gets no response frame
// - on command error a seven-bit field reports where the bad code sat
`ifndef IBM_MAP_VH
`define IBM_MAP_VH
`define IBM_ADDR_CTRL       16'h0104
`define IBM_ADDR_STAT       16'h0110
`define IBM_CTRL_EN_BIT     31
`define IBM_CTRL_CHK_BIT    30
`define IBM_CTRL_RST_BIT    29
`define IBM_CTRL_QUE_HI     23
`define IBM_CTRL_QUE_LO     22
`define IBM_CTRL_PORT_HI    18
`define IBM_CTRL_PORT_LO    16
`define IBM_QUE_RST         2'h1
`define IBM_PORT_RST        3'h0
`define IBM_PORT_NUM        3'h3
`define IBM_TAG_RST         16'h40FE
`define IBM_FORMAT          16'h9800
`define IBM_CODE_A          16'h0001
`define IBM_CODE_B          16'h0002
`define IBM_MAX_LEN         10'd320
`define IBM_CMD_END         8'h00
`define IBM_CMD_WRITE       8'h01
`define IBM_CMD_READ        8'h02
`define IBM_IDX_TAG_HI      10'd12
`define IBM_IDX_TAG_LO      10'd13
`define IBM_IDX_FMT_HI      10'd14
`define IBM_IDX_FMT_LO      10'd15
`define IBM_IDX_CODE_HI     10'd16
`define IBM_IDX_CODE_LO     10'd17
`define IBM_IDX_DA_LAST     10'd5
`define IBM_ST_GOOD_BIT     31
`define IBM_ST_TXD_BIT      30
`define IBM_ST_EXD_BIT      29
`define IBM_ST_MM_BIT       14
`define IBM_ST_FMT_BIT      13
`define IBM_ST_ACC_BIT      12
`define IBM_ST_CMD_BIT      11
`define IBM_ST_OVR_BIT      10
`endif

// [ibm_ctrl.v]
`timescale 1ns/100ps
`include "ibm_map.vh"
module ibm_ctrl
(
	input  wire        clk_in,
	input  wire        nrst_in,
	input  wire        mgmt_enable_strap_pin_in,
	input  wire [15:0] addr_in,
	input  wire [31:0] wdata_in,
	input  wire        wr_in,
	input  wire        rd_in,
	output reg  [31:0] rdata_out,
	input  wire [47:0] mac_addr_in,
	input  wire        rx_valid_in,
	input  wire        rx_sof_in,
	input  wire        rx_eof_in,
	input  wire [7:0]  rx_byte_in,
	input  wire [2:0]  rx_port_in,
	input  wire        tx_done_in,
	output reg         cmd_valid_out,
	output reg         cmd_write_out,
	output reg  [23:0] cmd_addr_out,
	output reg  [31:0] cmd_wdata_out,
	output reg         tx_req_out,
	output reg  [1:0]  tx_queue_out,
	output reg  [2:0]  tx_port_out
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_HDR  = 3'h1;
	localparam [2:0] ST_CMD  = 3'h2;
	localparam [2:0] ST_TAIL = 3'h3;
	localparam [2:0] ST_SKIP = 3'h4;

	reg  [1:0]  rst_sync_r;
	wire        rst_n;
	reg         strap_done_r;
	reg         en_r;
	reg         chk_r;
	reg         soft_rst_r;
	reg  [1:0]  que_r;
	reg  [2:0]  port_r;
	reg  [15:0] tag_r;
	reg         good_r;
	reg         txd_r;
	reg         exd_r;
	reg         mm_r;
	reg         fmt_r;
	reg         acc_r;
	reg         cerr_r;
	reg         ovr_r;
	reg  [6:0]  loc_r;
	reg  [2:0]  state_r;
	reg  [9:0]  cnt_r;
	reg         da_ok_r;
	reg  [15:0] hw_r;
	reg         mgmt_r;
	reg         resp_ok_r;
	reg         err_r;
	reg         big_r;
	reg         pend_r;
	reg  [2:0]  sub_r;
	reg  [6:0]  cidx_r;
	reg  [7:0]  code_r;
	reg  [23:0] caddr_r;
	reg  [31:0] cdata_r;
	wire [9:0]  idx;
	wire [15:0] hw_now;
	wire [5:0]  da_hit;
	wire        da_phase;
	wire        byte_ok;
	wire [31:0] ctrl_word;
	wire [31:0] stat_word;
	genvar      g;
	wire        tag_hit;
	wire        frm_big;
	wire        code_known;

	assign rst_n = rst_sync_r[1];
	assign idx = rx_sof_in ? 10'd0 : cnt_r;
	assign hw_now = {hw_r[7:0], rx_byte_in};
	assign da_phase = (idx <= `IBM_IDX_DA_LAST);
	assign byte_ok = da_phase & da_hit[idx[2:0]];
	assign tag_hit = (hw_now == tag_r);
	// limit covers the zero pad and check sequence carried in the stream
	// a new frame start drops the size flag of the previous frame
	assign frm_big = (big_r & ~rx_sof_in) | (idx >= `IBM_MAX_LEN);
	assign code_known = (code_r == `IBM_CMD_WRITE) | (code_r == `IBM_CMD_READ);
	assign ctrl_word = {en_r, chk_r, 6'h00, que_r, 3'h0, port_r, tag_r};
	assign stat_word = {good_r, txd_r, exd_r, 14'h0000, mm_r, fmt_r, acc_r, cerr_r,
		ovr_r, 3'h0, loc_r};

	// one compare per switch address byte, first byte on the wire from the top
	generate
		for (g = 0; g < 6; g = g + 1)
		begin : g_da
			assign da_hit[g] = (rx_byte_in == mac_addr_in[47 - 8 * g -: 8]);
		end
	endgenerate

	always @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end

	// control register
	always @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_done_r <= 1'b0;
			en_r <= 1'b0;
			chk_r <= 1'b0;
			soft_rst_r <= 1'b0;
			que_r <= `IBM_QUE_RST;
			port_r <= `IBM_PORT_RST;
			tag_r <= `IBM_TAG_RST;
		end
		else
		begin
			soft_rst_r <= 1'b0;
			if (!strap_done_r)
			begin
				strap_done_r <= 1'b1;
				en_r <= ~mgmt_enable_strap_pin_in;
			end
			else if (wr_in && addr_in == `IBM_ADDR_CTRL)
			begin
				en_r <= wdata_in[`IBM_CTRL_EN_BIT];
				chk_r <= wdata_in[`IBM_CTRL_CHK_BIT];
				soft_rst_r <= wdata_in[`IBM_CTRL_RST_BIT];
				que_r <= wdata_in[`IBM_CTRL_QUE_HI:`IBM_CTRL_QUE_LO];
				port_r <= wdata_in[`IBM_CTRL_PORT_HI:`IBM_CTRL_PORT_LO];
				tag_r <= wdata_in[15:0];
			end
		end
	end

	// read port
	always @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			rdata_out <= 32'h00000000;
		else if (rd_in && addr_in == `IBM_ADDR_CTRL)
			rdata_out <= ctrl_word;
		else if (rd_in && addr_in == `IBM_ADDR_STAT)
			rdata_out <= stat_word;
		else
			rdata_out <= 32'h00000000;
	end

	// frame processing
	always @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			good_r <= 1'b0;
			txd_r <= 1'b0;
			exd_r <= 1'b0;
			mm_r <= 1'b0;
			fmt_r <= 1'b0;
			acc_r <= 1'b0;
			cerr_r <= 1'b0;
			ovr_r <= 1'b0;
			loc_r <= 7'h00;
			state_r <= ST_IDLE;
			cnt_r <= 10'd0;
			da_ok_r <= 1'b0;
			hw_r <= 16'h0000;
			mgmt_r <= 1'b0;
			resp_ok_r <= 1'b0;
			err_r <= 1'b0;
			big_r <= 1'b0;
			pend_r <= 1'b0;
			sub_r <= 3'h0;
			cidx_r <= 7'h00;
			code_r <= 8'h00;
			caddr_r <= 24'h000000;
			cdata_r <= 32'h00000000;
			cmd_valid_out <= 1'b0;
			cmd_write_out <= 1'b0;
			cmd_addr_out <= 24'h000000;
			cmd_wdata_out <= 32'h00000000;
			tx_req_out <= 1'b0;
			tx_queue_out <= `IBM_QUE_RST;
			tx_port_out <= `IBM_PORT_RST;
		end
		else if (soft_rst_r)
		begin
			good_r <= 1'b0;
			txd_r <= 1'b0;
			exd_r <= 1'b0;
			mm_r <= 1'b0;
			fmt_r <= 1'b0;
			acc_r <= 1'b0;
			cerr_r <= 1'b0;
			ovr_r <= 1'b0;
			loc_r <= 7'h00;
			state_r <= ST_IDLE;
			mgmt_r <= 1'b0;
			pend_r <= 1'b0;
			// partial frame state is dropped as well
			da_ok_r <= 1'b0;
			hw_r <= 16'h0000;
			cnt_r <= 10'd0;
			resp_ok_r <= 1'b0;
			err_r <= 1'b0;
			big_r <= 1'b0;
			sub_r <= 3'h0;
			cidx_r <= 7'h00;
			code_r <= 8'h00;
			caddr_r <= 24'h000000;
			cdata_r <= 32'h00000000;
			cmd_valid_out <= 1'b0;
			tx_req_out <= 1'b0;
		end
		else
		begin
			cmd_valid_out <= 1'b0;
			tx_req_out <= 1'b0;
			if (tx_done_in && pend_r)
			begin
				txd_r <= 1'b1;
				pend_r <= 1'b0;
			end
			if (rx_valid_in)
			begin
				hw_r <= hw_now;
				cnt_r <= (idx == 10'h3FF) ? idx : idx + 10'd1;
				big_r <= frm_big;
				if (rx_sof_in)
				begin
					da_ok_r <= byte_ok;
					mgmt_r <= 1'b0;
					resp_ok_r <= 1'b0;
					err_r <= 1'b0;
					// reserved port codes never match an ingress port
					if (en_r && port_r < `IBM_PORT_NUM && rx_port_in == port_r)
						state_r <= ST_HDR;
					else
						state_r <= ST_SKIP;
				end
				else
				begin
					case (state_r)
					// header: address, tag, format and access code
					ST_HDR:
					begin
						if (da_phase)
							da_ok_r <= da_ok_r & byte_ok;
						if (idx == `IBM_IDX_TAG_LO)
						begin
							if (!tag_hit)
								state_r <= ST_SKIP;
							else
							begin
								mgmt_r <= 1'b1;
								txd_r <= tx_done_in & pend_r;
								exd_r <= 1'b0;
								fmt_r <= 1'b0;
								acc_r <= 1'b0;
								cerr_r <= 1'b0;
								ovr_r <= 1'b0;
								loc_r <= 7'h00;
								mm_r <= chk_r & ~da_ok_r;
								if (chk_r && !da_ok_r)
								begin
									mgmt_r <= 1'b0;
									state_r <= ST_SKIP;
								end
							end
						end
						if (idx == `IBM_IDX_FMT_LO && hw_now != `IBM_FORMAT)
						begin
							fmt_r <= 1'b1;
							err_r <= 1'b1;
						end
						if (idx == `IBM_IDX_CODE_LO)
						begin
							resp_ok_r <= 1'b1;
							sub_r <= 3'h0;
							cidx_r <= 7'h00;
							if (hw_now != `IBM_CODE_A && hw_now != `IBM_CODE_B)
							begin
								acc_r <= 1'b1;
								err_r <= 1'b1;
								state_r <= ST_TAIL;
							end
							else if (err_r)
								state_r <= ST_TAIL;
							else
								state_r <= ST_CMD;
						end
					end
					// command: code, three address bytes, four data bytes
					ST_CMD:
					begin
						sub_r <= sub_r + 3'h1;
						if (sub_r == 3'h0)
						begin
							code_r <= rx_byte_in;
							if (rx_byte_in == `IBM_CMD_END)
							begin
								exd_r <= 1'b1;
								state_r <= ST_TAIL;
							end
							else if (rx_byte_in != `IBM_CMD_WRITE &&
								rx_byte_in != `IBM_CMD_READ)
							begin
								cerr_r <= 1'b1;
								loc_r <= cidx_r;
								err_r <= 1'b1;
								state_r <= ST_TAIL;
							end
						end
						else if (sub_r <= 3'h3)
							caddr_r <= {caddr_r[15:0], rx_byte_in};
						else if (sub_r <= 3'h6)
							cdata_r <= {cdata_r[23:0], rx_byte_in};
						else
						begin
							cidx_r <= cidx_r + 7'h01;
							if (code_known && !frm_big)
							begin
								cmd_valid_out <= 1'b1;
								cmd_write_out <= (code_r == `IBM_CMD_WRITE);
								cmd_addr_out <= caddr_r;
								cmd_wdata_out <= {cdata_r[23:0], rx_byte_in};
							end
						end
					end
					// rest of a skipped or finished frame is ignored
					ST_SKIP, ST_TAIL:
					begin
						state_r <= state_r;
					end
					default:
					begin
						state_r <= state_r;
					end
					endcase
				end
				// frame end: flags and response request
				if (rx_eof_in)
				begin
					state_r <= ST_IDLE;
					if (mgmt_r && state_r != ST_HDR)
					begin
						if (state_r == ST_CMD && !err_r)
							exd_r <= 1'b1;
						// oversize frames never request a response
						if (frm_big)
							ovr_r <= 1'b1;
						else
						begin
							if (!err_r)
								good_r <= 1'b1;
							if (resp_ok_r)
							begin
								tx_req_out <= 1'b1;
								tx_queue_out <= que_r;
								tx_port_out <= port_r;
								pend_r <= 1'b1;
							end
						end
					end
				end
			end
		end
	end

endmodule // ibm_ctrl

// [ibm_checker.sv]
`timescale 1ns/100ps
`include "ibm_map.vh"
module ibm_checker
(
	input wire		clk_in,
	input wire		nrst_in,
	input wire		mgmt_enable_strap_pin_in,
	input wire [15:0]	addr_in,
	input wire [31:0]	wdata_in,
	input wire		wr_in,
	input wire		rd_in,
	input wire [31:0]	rdata_out,
	input wire [47:0]	mac_addr_in,
	input wire		rx_valid_in,
	input wire		rx_sof_in,
	input wire		rx_eof_in,
	input wire [7:0]	rx_byte_in,
	input wire [2:0]	rx_port_in,
	input wire		tx_done_in,
	input wire		cmd_valid_out,
	input wire		cmd_write_out,
	input wire [23:0]	cmd_addr_out,
	input wire [31:0]	cmd_wdata_out,
	input wire		tx_req_out,
	input wire [1:0]	tx_queue_out,
	input wire [2:0]	tx_port_out
);
	reg [9:0]	cnt_r;
	reg [1:0]	que_r;
	reg [2:0]	prt_r;
	reg		chk_r;
	reg		bad_r;
	wire		cwr = wr_in && addr_in == `IBM_ADDR_CTRL;
	always @(posedge clk_in or negedge nrst_in)
		if (!nrst_in)
		begin
			cnt_r <= 10'h0;
			que_r <= `IBM_QUE_RST;
			prt_r <= `IBM_PORT_RST;
			chk_r <= 1'b0;
			bad_r <= 1'b0;
		end
		else
		begin
			if (cwr)
			begin
				que_r <= wdata_in[23:22];
				prt_r <= wdata_in[18:16];
				chk_r <= wdata_in[30];
			end
			if (rx_valid_in && rx_sof_in)
				bad_r <= rx_byte_in != mac_addr_in[47:40];
			else if (rx_valid_in && cnt_r < 10'h6)
				bad_r <= bad_r | (rx_byte_in != mac_addr_in[8*(5-int'(cnt_r))+:8]);
			if (rx_valid_in)
				cnt_r <= rx_sof_in ? 10'h1 : cnt_r + 10'h1;
		end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	AST_OVR: assert property (rx_valid_in && rx_eof_in && cnt_r >= 10'd320 |=> !tx_req_out)
		else $error("response after oversize frame");
	AST_QUE: assert property (tx_req_out |-> tx_queue_out == que_r)
		else $error("wrong response queue");
	AST_PRT: assert property (tx_req_out |-> tx_port_out == prt_r)
		else $error("wrong response port");
	AST_RSV: assert property (prt_r > 3'h2 |-> !cmd_valid_out && !tx_req_out)
		else $error("activity on reserved port code");
	AST_MM: assert property (chk_r && bad_r |-> !cmd_valid_out && !tx_req_out)
		else $error("foreign address frame not discarded");
	AST_SC: assert property ($past(rd_in && addr_in == `IBM_ADDR_CTRL) |-> !rdata_out[29])
		else $error("reset bit reads one");
	AST_RD0: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
		else $error("read data outside its cycle");
	AST_CMD: assert property (cmd_valid_out |-> $past(rx_valid_in) ##1 !cmd_valid_out)
		else $error("command pulse not tied to a byte");
	AST_TX: assert property (tx_req_out |-> $past(rx_valid_in && rx_eof_in) ##1 !tx_req_out)
		else $error("response request not after frame end");
	cover property (tx_req_out);
	cover property (cmd_valid_out);
	cover property (rx_valid_in && rx_eof_in && cnt_r >= 10'd320);
endmodule // ibm_checker
bind ibm_ctrl ibm_checker u_chk (.*);

// [ibm_peer.sv]
`timescale 1ns/100ps
module ibm_peer
#(parameter DLY = 5)
(
	input wire		clk_in,
	input wire		tx_req_out,
	output logic		rx_valid_in,
	output logic		rx_sof_in,
	output logic		rx_eof_in,
	output logic [7:0]	rx_byte_in,
	output logic		tx_done_in
);
	logic [7:0] mem [0:399];
	initial
	begin
		rx_valid_in = 1'b0;
		rx_sof_in = 1'b0;
		rx_eof_in = 1'b0;
		rx_byte_in = 8'h00;
		tx_done_in = 1'b0;
	end
	// whole frame incl. zeros and check sequence, may exceed the limit
	task send(input int n);
		for (int i = 0; i < n; i++)
		begin
			if (i % 7 == 3)
			begin
				@(posedge clk_in);
				rx_valid_in <= 1'b0;
				rx_byte_in <= ~rx_byte_in;
			end
			@(posedge clk_in);
			rx_valid_in <= 1'b1;
			rx_sof_in <= i == 0;
			rx_eof_in <= i == n - 1;
			rx_byte_in <= mem[i];
		end
		@(posedge clk_in);
		rx_valid_in <= 1'b0;
		rx_eof_in <= 1'b0;
		rx_byte_in <= ~rx_byte_in;
	endtask
	always @(posedge clk_in)
		if (tx_req_out)
		begin
			repeat (DLY) @(posedge clk_in);
			tx_done_in <= 1'b1;
			@(posedge clk_in);
			tx_done_in <= 1'b0;
		end
endmodule // ibm_peer

// [testbench.sv]
`timescale 1ns/100ps
`include "ibm_map.vh"
module testbench;
	logic		clk_in, nrst_in, mgmt_enable_strap_pin_in, wr_in, rd_in, tx_done_in;
	logic		rx_valid_in, rx_sof_in, rx_eof_in, cmd_valid_out, cmd_write_out, tx_req_out;
	logic [15:0]	addr_in;
	logic [31:0]	wdata_in, rdata_out, cmd_wdata_out, r;
	logic [47:0]	mac_addr_in;
	logic [7:0]	rx_byte_in;
	logic [2:0]	rx_port_in, tx_port_out;
	logic [1:0]	tx_queue_out;
	logic [23:0]	cmd_addr_out;
	int		n_errors, num_checks, ncmd, ntx, cyc;
	ibm_ctrl u_dut (.*);
	ibm_peer u_peer (.*);
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
	begin
		cyc++;
		if (cmd_valid_out === 1'b1)
			ncmd++;
		if (tx_req_out === 1'b1)
			ntx++;
		if (cyc == 20000)
		begin
			n_errors++;
			summarize;
		end
	end
	task ck(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task rd(input logic [15:0] a);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 r = rdata_out;
	endtask
	task fr(input logic [7:0] da, f, c, k, input int n);
		logic [119:0] h;
		h = {16'h40FE, 8'h98, f, 8'h00, c, 8'h01, 56'h123456DEADBEEF, k};
		for (int i = 0; i < 400; i++)
			u_peer.mem[i] = 8'h00;
		for (int i = 0; i < 6; i++)
			u_peer.mem[i] = mac_addr_in[8*(5-i)+:8];
		u_peer.mem[0] = da;
		for (int i = 0; i < 15; i++)
			u_peer.mem[12+i] = h[8*(14-i)+:8];
		ncmd = 0;
		ntx = 0;
		u_peer.send(n);
		repeat (12) @(posedge clk_in);
	endtask
	task t_reset;
		rd(`IBM_ADDR_CTRL);
		ck(r, 32'h804040FE);
		rd(`IBM_ADDR_STAT);
		ck(r, 32'h0);
		rd(16'h0108);
		ck(r, 32'h0);
	endtask
	task t_good;
		wr(`IBM_ADDR_CTRL, 32'hC08140FE);
		fr(8'h02, 8'h00, 8'h01, 8'h00, 64);
		ck(ncmd, 1);
		ck(ntx, 1);
		ck(tx_queue_out, 32'h2);
		ck(tx_port_out, 32'h1);
		ck({cmd_write_out, cmd_addr_out}, 32'h01123456);
		ck(cmd_wdata_out, 32'hDEADBEEF);
		rd(`IBM_ADDR_STAT);
		ck(r, 32'hE0000000);
		fr(8'h02, 8'h00, 8'h01, 8'h02, 64);
		ck(ncmd, 2);
		ck({cmd_write_out, cmd_addr_out}, 32'h0);
		rd(`IBM_ADDR_STAT);
		ck(r, 32'hE0000000);
	endtask
	task t_err;
		static logic [7:0] f [3] = '{8'h01, 8'h00, 8'h00};
		static logic [7:0] c [3] = '{8'h01, 8'h03, 8'h01};
		static logic [7:0] k [3] = '{8'h00, 8'h00, 8'h07};
		static logic [31:0] e [3] = '{32'hC0002000, 32'hC0001000, 32'hC0000801};
		for (int i = 0; i < 3; i++)
		begin
			fr(8'h02, f[i], c[i], k[i], 64);
			ck(ncmd, i / 2);
			rd(`IBM_ADDR_STAT);
			ck(r, e[i]);
		end
	endtask
	task t_size;
		fr(8'h02, 8'h00, 8'h01, 8'h00, 320);
		rd(`IBM_ADDR_STAT);
		ck(r, 32'hE0000000);
		fr(8'h02, 8'h00, 8'h01, 8'h00, 321);
		ck(ntx, 0);
		rd(`IBM_ADDR_STAT);
		ck(r, 32'hA0000400);
	endtask
	task t_addr;
		fr(8'hFF, 8'h00, 8'h01, 8'h00, 64);
		ck(ntx + ncmd, 0);
		rd(`IBM_ADDR_STAT);
		ck(r[14], 1'b1);
		wr(`IBM_ADDR_CTRL, 32'h808140FE);
		fr(8'hFF, 8'h00, 8'h01, 8'h00, 64);
		rd(`IBM_ADDR_STAT);
		ck(r, 32'hE0000000);
	endtask
	task t_soft;
		wr(`IBM_ADDR_CTRL, 32'hA08140FE);
		rd(`IBM_ADDR_STAT);
		ck(r, 32'h0);
		rd(`IBM_ADDR_CTRL);
		ck(r, 32'h808140FE);
	endtask
	task t_port;
		wr(`IBM_ADDR_CTRL, 32'h808340FE);
		rx_port_in <= 3'h3;
		fr(8'h02, 8'h00, 8'h01, 8'h00, 64);
		ck(ncmd + ntx, 0);
		rd(`IBM_ADDR_STAT);
		ck(r, 32'h0);
	endtask
	task t_strap;
		@(posedge clk_in);
		mgmt_enable_strap_pin_in <= 1'b1;
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		rx_port_in <= 3'h0;
		repeat (4) @(posedge clk_in);
		rd(`IBM_ADDR_CTRL);
		ck(r, 32'h004040FE);
		fr(8'h02, 8'h00, 8'h01, 8'h00, 64);
		ck(ncmd + ntx, 0);
		rd(`IBM_ADDR_STAT);
		ck(r, 32'h0);
	endtask
	task summarize;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		nrst_in = 1'b0;
		mgmt_enable_strap_pin_in = 1'b0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 16'h0;
		wdata_in = 32'h0;
		mac_addr_in = 48'h021122334455;
		rx_port_in = 3'h1;
		repeat (16) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		t_reset;
		t_good;
		t_err;
		t_size;
		t_addr;
		t_soft;
		t_port;
		t_strap;
		summarize;
	end
endmodule // testbench
